/* sri_pkg.sv */
// Shared constants and types for the safety restart interlock
package sri_pkg;
    // Widths
    localparam int CRC_W = 32;
    localparam int TYPE_W = 8;
    localparam int LOG_DEPTH = 5;
    localparam int TIME_W = 24;
    // Values after reset
    localparam logic [CRC_W-1:0] CRC_RST = 32'h00000000;
    // Drive type of this module; value is arbitrary
    localparam logic [TYPE_W-1:0] OWN_TYPE = 8'h5A;
    // Acknowledge sequence states
    typedef enum logic [3:0] {
        ACK_IDLE = 4'b0001,
        ACK_WAIT_PRESS = 4'b0010,
        ACK_WAIT_REL = 4'b0100,
        ACK_DONE = 4'b1000
    } sri_ack_type;
    // Timed stop states
    typedef enum logic [3:0] {
        STP_RUN = 4'b0001,
        STP_TIMING = 4'b0010,
        STP_STO = 4'b0100,
        STP_SOS = 4'b1000
    } sri_stop_type;
endpackage

/* sri_crc_log.sv */
// History of the most recently applied configuration CRCs
`timescale 1ns/1ns
`default_nettype none
module sri_crc_log
#(
    parameter int DEPTH = sri_pkg::LOG_DEPTH
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // New entry
    input wire logic push,
    input wire logic [sri_pkg::CRC_W-1:0] crc_in,
    // Read port
    input wire logic [2:0] rd_idx,
    output logic [sri_pkg::CRC_W-1:0] rd_crc
);
    import sri_pkg::*;

    // Read index is three bits wide, so at most eight entries
    if (DEPTH < 1 || DEPTH > 8)
    begin : g_bad_depth
        $error("sri_crc_log: DEPTH must be 1 to 8");
    end

    logic [CRC_W-1:0] log_r [DEPTH];
    logic [CRC_W-1:0] log_nxt [DEPTH];
    logic [CRC_W-1:0] rd_crc_nxt;

    // Shift history, newest at entry 0
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_ent
            if (gi == 0)
            begin : g_head
                always_comb
                begin
                    log_nxt[gi] = push ? crc_in : log_r[gi];
                end
            end
            else
            begin : g_tail
                always_comb
                begin
                    log_nxt[gi] = push ? log_r[gi-1] : log_r[gi];
                end
            end
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    log_r[gi] <= CRC_RST;
                else
                    log_r[gi] <= log_nxt[gi];
            end
        end
    endgenerate

    // Registered read, unmapped index reads zero
    always_comb
    begin
        rd_crc_nxt = CRC_RST;
        if (32'(rd_idx) < DEPTH)
            rd_crc_nxt = log_r[rd_idx];
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rd_crc <= CRC_RST;
        else
            rd_crc <= rd_crc_nxt;
    end

    // After a push the newest entry holds the pushed CRC
    a_log_newest: assert property (
        @(posedge clock) disable iff (sys_rst)
        push |=> log_r[0] == $past(crc_in))
        else $error("newest log entry not the pushed CRC");
endmodule
`default_nettype wire

/* sri_top.sv */
// Safety restart interlock, timed stop monitor and configuration check
`timescale 1ns/1ns
`default_nettype none
module sri_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // STO request and acknowledge edges from the functional system
    input wire logic sto_req,
    input wire logic ack_press,
    input wire logic ack_release,
    // Timed stop requests and interval in cycles
    input wire logic ss1_req,
    input wire logic ss2_req,
    input wire logic [sri_pkg::TIME_W-1:0] stop_time,
    // Configuration load
    input wire logic cfg_load,
    input wire logic [sri_pkg::TYPE_W-1:0] cfg_type,
    input wire logic [sri_pkg::CRC_W-1:0] cfg_crc,
    // Restart command and error report
    input wire logic restart_cmd,
    input wire logic fault_in,
    // Log read
    input wire logic [2:0] log_idx,
    output logic [sri_pkg::CRC_W-1:0] log_crc,
    // Status
    output logic torque_en,
    output logic sto_active,
    output logic sos_active,
    output logic cfg_ok,
    output logic cfg_reject,
    output logic fault
);
    import sri_pkg::*;

    sri_ack_type ack_r, ack_nxt;
    sri_stop_type stp_r, stp_nxt;
    logic [TIME_W-1:0] tmr_r, tmr_nxt;
    logic sos_sel_r, sos_sel_nxt;
    logic cfg_ok_r, cfg_ok_nxt;
    logic rej_r, rej_nxt;
    logic flt_r, flt_nxt;
    logic ten_r, ten_nxt;
    logic sto_act_r, sto_act_nxt;
    logic sos_act_r, sos_act_nxt;
    logic push;

    // Acknowledge sequencer: request, withdrawal, press, release
    always_comb
    begin
        ack_nxt = ack_r;
        case (ack_r)
            ACK_IDLE:
                if (sto_req)
                    ack_nxt = ACK_WAIT_PRESS;
            ACK_WAIT_PRESS:
                if (!sto_req && ack_press)
                    ack_nxt = ACK_WAIT_REL;
            ACK_WAIT_REL:
                if (sto_req)
                    ack_nxt = ACK_WAIT_PRESS;
                else if (ack_release)
                    ack_nxt = ACK_DONE;
            ACK_DONE:
                ack_nxt = sto_req ? ACK_WAIT_PRESS : ACK_IDLE;
            default:
                ack_nxt = ACK_WAIT_PRESS;
        endcase
        if (restart_cmd)
            ack_nxt = ACK_WAIT_PRESS;
    end

    // Timed stop monitor; axis ramp is the functional side's job
    always_comb
    begin
        stp_nxt = stp_r;
        tmr_nxt = tmr_r;
        sos_sel_nxt = sos_sel_r;
        case (stp_r)
            STP_RUN:
                if (ss1_req || ss2_req)
                begin
                    stp_nxt = STP_TIMING;
                    tmr_nxt = stop_time;
                    sos_sel_nxt = !ss1_req;
                end
            STP_TIMING:
                if (tmr_r == '0)
                    stp_nxt = sos_sel_r ? STP_SOS : STP_STO;
                else
                    tmr_nxt = tmr_r - 1'b1;
            STP_SOS:
                if (!ss2_req)
                    stp_nxt = STP_RUN;
            STP_STO:
                stp_nxt = STP_STO;
            default:
                stp_nxt = STP_STO;
        endcase
        if (restart_cmd)
        begin
            stp_nxt = STP_RUN;
            tmr_nxt = '0;
        end
    end

    // Configuration check, fault latch and restart
    always_comb
    begin
        cfg_ok_nxt = cfg_ok_r;
        rej_nxt = rej_r;
        flt_nxt = flt_r | fault_in;
        push = 1'b0;
        if (restart_cmd)
        begin
            cfg_ok_nxt = 1'b0;
            rej_nxt = 1'b0;
            flt_nxt = fault_in;
        end
        else if (cfg_load && !cfg_ok_r && !flt_r)
        begin
            if (cfg_type == OWN_TYPE)
            begin
                cfg_ok_nxt = 1'b1;
                push = 1'b1;
            end
            else
                rej_nxt = 1'b1;
        end
    end

    // Torque only with valid config, no fault, no STO, no stop
    always_comb
    begin
        ten_nxt = cfg_ok_nxt && !flt_nxt && stp_nxt == STP_RUN
            && (ack_nxt == ACK_IDLE || ack_nxt == ACK_DONE)
            && !sto_req;
    end

    // Status decoded from next state so the outputs come from flops
    always_comb
    begin
        sto_act_nxt = stp_nxt == STP_STO || ack_nxt == ACK_WAIT_PRESS
            || ack_nxt == ACK_WAIT_REL;
        sos_act_nxt = stp_nxt == STP_SOS;
    end

    // State registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ack_r <= ACK_WAIT_PRESS;
            sto_act_r <= 1'b1;
            sos_act_r <= 1'b0;
            stp_r <= STP_RUN;
            tmr_r <= '0;
            sos_sel_r <= 1'b0;
            cfg_ok_r <= 1'b0;
            rej_r <= 1'b0;
            flt_r <= 1'b0;
            ten_r <= 1'b0;
        end
        else
        begin
            ack_r <= ack_nxt;
            stp_r <= stp_nxt;
            tmr_r <= tmr_nxt;
            sos_sel_r <= sos_sel_nxt;
            cfg_ok_r <= cfg_ok_nxt;
            rej_r <= rej_nxt;
            flt_r <= flt_nxt;
            ten_r <= ten_nxt;
            sto_act_r <= sto_act_nxt;
            sos_act_r <= sos_act_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign torque_en = ten_r;
    assign sto_active = sto_act_r;
    assign sos_active = sos_act_r;
    assign cfg_ok = cfg_ok_r;
    assign cfg_reject = rej_r;
    assign fault = flt_r;

    // CRC history of accepted configurations
    sri_crc_log #(.DEPTH(LOG_DEPTH)) u_log
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .push(push),
        .crc_in(cfg_crc),
        .rd_idx(log_idx),
        .rd_crc(log_crc)
    );

    a_sto_holds: assert property (
        @(posedge clock) disable iff (sys_rst)
        sto_req |=> !torque_en)
        else $error("torque on during STO request");
    a_no_ack_early: assert property (
        @(posedge clock) disable iff (sys_rst)
        (ack_r == ACK_WAIT_PRESS && ack_press && sto_req && !restart_cmd)
        |=> ack_r == ACK_WAIT_PRESS)
        else $error("press taken while request present");
    a_ack_order: assert property (
        @(posedge clock) disable iff (sys_rst)
        (ack_r == ACK_WAIT_PRESS && !ack_press) |=> ack_r != ACK_DONE)
        else $error("ack completed without press");
    a_wrong_type: assert property (
        @(posedge clock) disable iff (sys_rst)
        (cfg_load && cfg_type != OWN_TYPE && !restart_cmd)
        |=> !$rose(cfg_ok))
        else $error("foreign configuration accepted");
    a_stop_expiry: assert property (
        @(posedge clock) disable iff (sys_rst)
        (stp_r == STP_TIMING && tmr_r == '0 && !restart_cmd)
        |=> (sto_active || sos_active))
        else $error("timed stop did not end in STO or SOS");
    a_stop_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (stp_r == STP_TIMING && tmr_r != '0 && !restart_cmd)
        |=> stp_r == STP_TIMING && tmr_r == $past(tmr_r) - 1'b1)
        else $error("stop timer not counting");
    a_restart_clr: assert property (
        @(posedge clock) disable iff (sys_rst)
        restart_cmd |=> !cfg_ok && !torque_en && stp_r == STP_RUN)
        else $error("restart did not clear state");
    a_fault_off: assert property (
        @(posedge clock) disable iff (sys_rst)
        fault |-> !torque_en)
        else $error("torque on with fault");
    a_log_push: assert property (
        @(posedge clock) disable iff (sys_rst)
        ($rose(cfg_ok) && log_idx == 3'h0 && $stable(log_idx))
        |=> log_crc == $past(cfg_crc, 2))
        else $error("accepted CRC not logged");

    c_ack_done: cover property (@(posedge clock) ack_r == ACK_DONE);
    c_sos: cover property (@(posedge clock) stp_r == STP_SOS);
    c_reject: cover property (@(posedge clock) $rose(cfg_reject));
    c_torque: cover property (@(posedge clock) $rose(torque_en));
endmodule
`default_nettype wire

/* sri_fcs_model.sv */
// Functional control system model: button edges and user restarts
`timescale 1ns/1ns
`default_nettype none
module sri_fcs_model
(
    // Clock
    input wire logic clock,
    // Operator controls
    input wire logic button,
    input wire logic user_rst,
    // Towards the safety module
    output logic ack_press,
    output logic ack_release,
    output logic restart_cmd
);
    logic button_r;
    // Button sampled on every clock, far above the minimum rate
    always_ff @(posedge clock)
    begin
        button_r <= button;
    end
    // Edges come only from a real button action
    assign ack_press = button & ~button_r;
    assign ack_release = ~button & button_r;
    // Restart only when the user asks for it
    assign restart_cmd = user_rst;
endmodule
`default_nettype wire

/* safety_restart_interlock_test.sv */
// Self-checking testbench for the safety restart interlock
`timescale 1ns/1ns
`default_nettype none
module safety_restart_interlock_test;
    import sri_pkg::*;
    logic clock, sys_rst, sto_req, ss1_req, ss2_req, cfg_load;
    logic restart_cmd, fault_in, button, user_rst, ack_press, ack_release;
    logic [TIME_W-1:0] stop_time;
    logic [TYPE_W-1:0] cfg_type;
    logic [CRC_W-1:0] cfg_crc, log_crc;
    logic [2:0] log_idx;
    logic torque_en, sto_active, sos_active, cfg_ok, cfg_reject, fault;
    int n_fail = 0;
    int cmp_count = 0;
    sri_top sri_top_i (.clock(clock), .sys_rst(sys_rst),
        .sto_req(sto_req), .ack_press(ack_press), .ack_release(ack_release),
        .ss1_req(ss1_req), .ss2_req(ss2_req), .stop_time(stop_time),
        .cfg_load(cfg_load), .cfg_type(cfg_type), .cfg_crc(cfg_crc),
        .restart_cmd(restart_cmd), .fault_in(fault_in), .log_idx(log_idx),
        .log_crc(log_crc), .torque_en(torque_en), .sto_active(sto_active),
        .sos_active(sos_active), .cfg_ok(cfg_ok), .cfg_reject(cfg_reject),
        .fault(fault));
    sri_fcs_model sri_fcs_model_i (.clock(clock), .button(button),
        .user_rst(user_rst), .ack_press(ack_press),
        .ack_release(ack_release), .restart_cmd(restart_cmd));
    // Clock generation
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic end_sim;
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic load(input logic [7:0] t, input logic [31:0] c);
        cfg_type = t;
        cfg_crc = c;
        cfg_load = 1'b1;
        cyc(1);
        cfg_load = 1'b0;
    endtask
    task automatic restart;
        user_rst = 1'b1;
        cyc(1);
        user_rst = 1'b0;
    endtask
    // Operator presses and releases the button
    task automatic ack;
        button = 1'b1;
        cyc(1);
        button = 1'b0;
        cyc(2);
    endtask
    task automatic arm(input logic [31:0] c);
        restart;
        load(OWN_TYPE, c);
        chk(cfg_ok, 1'b1, "config not accepted");
        sto_req = 1'b0;
        cyc(1);
        ack;
        chk(torque_en, 1'b1, "torque after ack");
        chk(sto_active, 1'b0, "sto after ack");
    endtask
    task automatic s_foreign;
        load(OWN_TYPE ^ 8'hFF, 32'h0BAD0BAD);
        chk(cfg_reject, 1'b1, "foreign type");
        chk(cfg_ok, 1'b0, "foreign ok");
        restart;
        chk(cfg_reject, 1'b0, "reject after restart");
    endtask
    task automatic s_ack;
        load(OWN_TYPE, 32'h11111111);
        ack;
        chk(torque_en, 1'b0, "ack during request");
        sto_req = 1'b0;
        button = 1'b1;
        cyc(1);
        button = 1'b0;
        sto_req = 1'b1;
        cyc(1);
        sto_req = 1'b0;
        cyc(3);
        chk(torque_en, 1'b0, "broken ack sequence");
        ack;
        chk(torque_en, 1'b1, "full ack");
        sto_req = 1'b1;
        cyc(1);
        chk(torque_en, 1'b0, "new request");
        chk(sto_active, 1'b1, "ack pending again");
    endtask
    task automatic s_log;
        for (int i = 0; i < 6; i++)
        begin
            restart;
            load(OWN_TYPE, 32'hC0DE0000 + i);
        end
        for (int j = 0; j < 6; j++)
        begin
            log_idx = 3'(j);
            cyc(2);
            chk(log_crc, j < 5 ? 32'hC0DE0005 - j : 32'h0, "log");
        end
        log_idx = 3'h0;
    endtask
    // Timed stop; the axis ramp is left to the functional side
    task automatic s_stop(input bit sos);
        arm(32'h5700 + sos);
        stop_time = 24'h000003;
        ss1_req = ~sos;
        ss2_req = 1'b1;
        cyc(1);
        chk(torque_en, 1'b0, "torque in stop");
        cyc(3);
        chk({sto_active, sos_active}, 2'b00, "stop early");
        cyc(1);
        chk({sto_active, sos_active}, {~sos, sos}, "stop state");
        ss1_req = 1'b0;
        ss2_req = 1'b0;
        cyc(2);
        chk({sto_active, sos_active}, {~sos, 1'b0}, "stop leave");
    endtask
    task automatic s_fault;
        arm(32'hFA000001);
        fault_in = 1'b1;
        cyc(1);
        fault_in = 1'b0;
        cyc(1);
        chk({fault, torque_en}, 2'b10, "fault");
        fault_in = 1'b1;
        restart;
        chk({fault, cfg_ok}, 2'b10, "fault over restart");
        load(OWN_TYPE, 32'hFA000002);
        cyc(1);
        chk(cfg_ok, 1'b0, "load under fault");
        chk(log_crc, 32'hFA000001, "log under fault");
        fault_in = 1'b0;
        restart;
        chk({fault, cfg_ok}, 2'b00, "restart");
        load(OWN_TYPE, 32'hFA000003);
        chk(cfg_ok, 1'b1, "load after restart");
    endtask
    // Main sequence
    initial
    begin
        {sys_rst, sto_req} = 2'b11;
        {ss1_req, ss2_req, cfg_load, fault_in, button, user_rst} = '0;
        stop_time = '0;
        cfg_type = '0;
        cfg_crc = '0;
        log_idx = 3'h0;
        cyc(3);
        sys_rst = 1'b0;
        cyc(1);
        chk({torque_en, sto_active, cfg_ok}, 3'b010, "reset");
        chk(log_crc, CRC_RST, "log reset");
        s_foreign;
        s_ack;
        s_log;
        s_stop(1'b0);
        s_stop(1'b1);
        s_fault;
        end_sim;
    end
    // Watchdog
    initial
    begin
        #200000;
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
